// File: bench/ext_mem_model.sv
// External data memory and timer one count source, seen from the core's pins.
// Assumes active low strobes that only count while their output enable is high.
`timescale 1ns/100ps
module ext_mem_model
    import core_timing_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire pin_drive_s read_pin,
    input wire pin_drive_s write_pin,
    input wire logic fetch_external,
    input wire logic pulse_go,
    output logic count_pin,
    output logic code_from_ext,
    output logic [15:0] reads,
    output logic [15:0] writes
);
    logic rd_low_reg;
    logic wr_low_reg;
    logic [1:0] low_cnt;
    wire logic rd_low = read_pin.oe && !read_pin.out;
    wire logic wr_low = write_pin.oe && !write_pin.out;

    // Code is served from here only while the core asks for external fetch
    assign code_from_ext = fetch_external;
    // Weak pull-up idles the line high; each request pulls it low for two clocks
    assign count_pin = (low_cnt == 2'h0);

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_low_reg <= 1'b0;
            wr_low_reg <= 1'b0;
            low_cnt <= 2'h0;
            reads <= 16'h0000;
            writes <= 16'h0000;
        end
        else
        begin
            rd_low_reg <= rd_low;
            wr_low_reg <= wr_low;
            // Edge counting, so a stretched strobe still counts once
            if (rd_low && !rd_low_reg)
                reads <= reads + 16'h0001;
            if (wr_low && !wr_low_reg)
                writes <= writes + 16'h0001;
            if (pulse_go)
                low_cnt <= 2'h2;
            else if (low_cnt != 2'h0)
                low_cnt <= low_cnt - 2'h1;
        end
    end
endmodule

// File: bench/tb_core_cycle_timing.sv
// Self-checking bench for the core cycle timing block.
// Assumes the package is compiled first and the memory model sits beside it.
`timescale 1ns/100ps
module tb_core_cycle_timing
    import core_timing_pkg::*;
;
    typedef struct {int cyc; int mc; logic [15:0] dp;} note_s;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic strap = 1'b0;
    logic instr_valid = 1'b0;
    instr_s instr = '{kind: KIND_GENERAL, bytes: 2'h1};
    logic [2:0] mem_stretch = 3'h0;
    logic dp_load = 1'b0;
    logic [15:0] dp_value = 16'h0000;
    logic [2:0] t_run = 3'h0;
    logic [2:0] t_fast = 3'h4;
    logic [2:0] t_mode = 3'h2;
    logic alt_en = 1'b1;
    logic pulse_go = 1'b0;
    logic t1_pin, fetch_ext, fetch_int, ready, mc_end, done, code_ext;
    logic [15:0] dp, reads, writes, exp_dp;
    logic [2:0][15:0] tval;
    pin_drive_s pin_wr, pin_rd;
    logic [7:0] rnd = 8'h4c;
    int n_fail = 0;
    int compares = 0;
    int n_rd, n_wr, cnt;
    int mcs = 0;
    logic busy = 1'b0;
    note_s notes[$];
    note_s got;

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    core_cycle_timing #(.NUM_TIMERS(3), .STRETCH_W(3)) dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
        .program_source_select(strap), .instr_valid(instr_valid), .instr(instr),
        .mem_stretch(mem_stretch), .data_pointer_load(dp_load),
        .data_pointer_value(dp_value), .timer_run(t_run), .timer_fast_sel(t_fast),
        .timer_count_mode(t_mode), .port_three_bit_five(t1_pin), .strobe_alt_en(alt_en),
        .fetch_external(fetch_ext), .fetch_internal(fetch_int), .instr_ready(ready),
        .machine_cycle_end(mc_end), .instr_done(done), .data_pointer(dp),
        .timer_value(tval), .port_three_bit_six(pin_wr), .port_three_bit_seven(pin_rd)
    );

    ext_mem_model mem_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .read_pin(pin_rd), .write_pin(pin_wr),
        .fetch_external(fetch_ext), .pulse_go(pulse_go), .count_pin(t1_pin),
        .code_from_ext(code_ext), .reads(reads), .writes(writes)
    );

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic do_reset(input logic pin);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        strap <= pin;
        repeat (5) @(posedge clk_sys);
        check("read pin", 32'h2, 32'(pin_rd));
        check("write pin", 32'h2, 32'(pin_wr));
        check("fetch pair", 32'h0, {fetch_ext, fetch_int});
        check("timer0", 32'h0, tval[0]);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check("fetch_external", !pin, fetch_ext);
        check("fetch_internal", pin, fetch_int);
        check("code source", !pin, code_ext);
        @(posedge clk_sys);
        strap <= !pin;
        repeat (3) @(posedge clk_sys);
        #1;
        check("held strap", !pin, fetch_ext);
        exp_dp = 16'h0000;
        n_rd = 0;
        n_wr = 0;
        $display("test reset with strap %0d done", pin);
    endtask

    task automatic run_instr(input instr_kind_e kind, input logic [1:0] nb, input logic [2:0] s);
        note_s n;
        int w;
        w = 0;
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr <= '{kind: kind, bytes: nb};
        mem_stretch <= s;
        do
        begin
            @(posedge clk_sys);
            w++;
        end
        while (ready !== 1'b1 && w < 100);
        instr_valid <= 1'b0;
        if (w >= 100)
        begin
            n_fail++;
            wrap_up();
        end
        case (kind)
            KIND_EXT_READ, KIND_EXT_WRITE: n.mc = 2;
            KIND_MOV_DIR_DIR: n.mc = 3;
            KIND_DATA_POINTER_INC: n.mc = 1;
            default: n.mc = (nb == 2'h0) ? 2 : nb + 1;
        endcase
        // Stretch lengthens only the machine cycles of external data moves
        if (kind == KIND_EXT_READ || kind == KIND_EXT_WRITE)
            n.cyc = n.mc * (s + 1);
        else
            n.cyc = n.mc;
        if (kind == KIND_DATA_POINTER_INC)
            exp_dp = exp_dp + 16'h0001;
        n_rd += (kind == KIND_EXT_READ && alt_en) ? 1 : 0;
        n_wr += (kind == KIND_EXT_WRITE && alt_en) ? 1 : 0;
        n.dp = exp_dp;
        notes.push_back(n);
    endtask

    task automatic drain();
        int w;
        w = 0;
        while ((notes.size() != 0 || busy) && w < 200)
        begin
            @(posedge clk_sys);
            w++;
        end
        check("queue drained", 32'h0, notes.size());
        #1;
        check("read strobes", n_rd, reads);
        check("write strobes", n_wr, writes);
    endtask

    task automatic load_dp(input logic [15:0] v);
        @(posedge clk_sys);
        dp_load <= 1'b1;
        dp_value <= v;
        @(posedge clk_sys);
        dp_load <= 1'b0;
        @(posedge clk_sys);
        #1;
        check("pointer load", v, dp);
        exp_dp = v;
    endtask

    // Done and the next accept may share an edge, so completion is judged first
    always @(posedge clk_sys)
    begin
        if (busy && mc_end === 1'b1)
            mcs++;
        if (busy && done === 1'b1)
        begin
            busy = 1'b0;
            if (notes.size() == 0)
                check("note queue", 32'h1, 32'h0);
            else
            begin
                got = notes.pop_front();
                check("cycles", got.cyc, cnt);
                check("machine cycles", got.mc, mcs);
                check("data_pointer", got.dp, dp);
            end
        end
        cnt++;
        if (rst_b && instr_valid && ready === 1'b1 && clk_en)
        begin
            busy = 1'b1;
            cnt = 0;
            mcs = 0;
        end
    end

    initial
    begin
        do_reset(1'b0);
        for (int i = 0; i < 20; i++)
        begin
            rnd = lfsr_next(rnd);
            run_instr(instr_kind_e'(3'(i % 5)), rnd[1:0], rnd[4:2]);
        end
        drain();
        $display("test instruction timing done");
        rnd = lfsr_next(rnd);
        load_dp({rnd, 8'h3c});
        run_instr(KIND_DATA_POINTER_INC, 2'h0, 3'h0);
        load_dp(16'hffff);
        run_instr(KIND_DATA_POINTER_INC, 2'h0, 3'h0);
        drain();
        $display("test data pointer done");
        @(posedge clk_sys);
        alt_en <= 1'b0;
        run_instr(KIND_EXT_READ, 2'h1, 3'h0);
        run_instr(KIND_EXT_WRITE, 2'h1, 3'h7);
        drain();
        $display("test strobes released done");
        do_reset(1'b1);
        @(posedge clk_sys);
        t_run <= 3'h7;
        for (int i = 0; i < 120; i++)
        begin
            @(posedge clk_sys);
            pulse_go <= (i % 8 == 4) && (i < 44);
        end
        // Enable low must freeze the timers even while they are told to run
        clk_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        check("legacy timer", 32'd10, tval[0]);
        check("count input timer", 32'd5, tval[1]);
        check("fast timer", 32'd120, tval[2]);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        t_run <= 3'h0;
        repeat (20) @(posedge clk_sys);
        #1;
        check("stopped legacy timer", 32'd10, tval[0]);
        check("stopped fast timer", 32'd120, tval[2]);
        $display("test timers done");
        wrap_up();
    end
endmodule

// File: pkg/core_timing_pkg.sv
// Shared constants and types for the core cycle timing block.
// Assumes one 20 MHz system clock and an instruction decoder upstream.
package core_timing_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;

    // Legacy timer rate: one increment per twelve input clocks
    localparam int unsigned PRESCALE_LEGACY = 12;
    localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_LEGACY - 1);
    localparam logic [3:0] PRESCALE_RESET = 4'h0;

    // Machine cycles per instruction class
    localparam logic [2:0] CYC_EXEC_EXTRA = 3'h1;
    localparam logic [2:0] CYC_EXT_DATA = 3'h2;
    localparam logic [2:0] CYC_MOV_DIR_DIR = 3'h3;
    localparam logic [2:0] CYC_DATA_POINTER_INC = 3'h1;
    localparam logic [2:0] CYC_LAST = 3'h1;

    localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;
    localparam logic [15:0] DATA_POINTER_STEP = 16'h0001;

    typedef enum logic [2:0] {
        KIND_GENERAL = 3'h0,
        KIND_EXT_READ = 3'h1,
        KIND_EXT_WRITE = 3'h2,
        KIND_MOV_DIR_DIR = 3'h3,
        KIND_DATA_POINTER_INC = 3'h4
    } instr_kind_e;

    typedef struct packed {
        instr_kind_e kind;
        logic [1:0] bytes;
    } instr_s;

    typedef enum logic [2:0] {
        ST_STRAP = 3'b001,
        ST_IDLE = 3'b010,
        ST_EXEC = 3'b100
    } seq_state_e;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_s;

    localparam pin_drive_s PIN_RELEASED = '{out: 1'b1, oe: 1'b0};

endpackage

// File: src/core_cycle_timing.sv
// Instruction cycle sequencer, program source strap, timers, data strobes.
// Assumes a decoder presents one instruction at a time with its byte count.
//
// What this block does
// - Program source pin low: fetch all code from external memory.
// - Program source pin high: fetch code from internal flash.
// - One machine cycle equals one input clock, no divide by twelve.
// - No dummy memory cycles; strobes only on real data accesses.
// - After reset timers step once every twelve input clocks.
// - Each timer may be switched to step every input clock.
// - One machine cycle per instruction byte plus one for execution.
// - External data read through the data pointer takes two clocks.
// - Direct to direct move takes three clocks.
// - Data pointer increment finishes in a single clock.
// - External access stretch lengthens each machine cycle, slowing execution.
// - Flags and results unchanged; only clock counts differ.
// - Port three bit six acts as external data write strobe.
// - Port three bit seven acts as external data read strobe.
// - Port three bit five is the external count input of timer one.
`timescale 1ns/100ps
module core_cycle_timing
    import core_timing_pkg::*;
#(
    parameter int NUM_TIMERS = 3,
    parameter int STRETCH_W = 3
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic program_source_select,
    input wire logic instr_valid,
    input wire instr_s instr,
    input wire logic [STRETCH_W-1:0] mem_stretch,
    input wire logic data_pointer_load,
    input wire logic [15:0] data_pointer_value,
    input wire logic [NUM_TIMERS-1:0] timer_run,
    input wire logic [NUM_TIMERS-1:0] timer_fast_sel,
    input wire logic [NUM_TIMERS-1:0] timer_count_mode,
    input wire logic port_three_bit_five,
    input wire logic strobe_alt_en,
    output logic fetch_external,
    output logic fetch_internal,
    output logic instr_ready,
    output logic machine_cycle_end,
    output logic instr_done,
    output logic [15:0] data_pointer,
    output logic [NUM_TIMERS-1:0][15:0] timer_value,
    output pin_drive_s port_three_bit_six,
    output pin_drive_s port_three_bit_seven
);

    seq_state_e state_reg;
    seq_state_e state_next;
    instr_kind_e kind_reg;
    instr_kind_e kind_next;
    logic [2:0] cycles_left_reg;
    logic [2:0] cycles_left_next;
    logic [STRETCH_W-1:0] stretch_reg;
    logic [STRETCH_W-1:0] stretch_next;
    logic [STRETCH_W-1:0] stretch_cnt_reg;
    logic [STRETCH_W-1:0] stretch_cnt_next;
    logic fetch_external_next;
    logic fetch_internal_next;
    logic ready_next;
    logic mc_end_next;
    logic done_next;
    logic [15:0] data_pointer_next;
    pin_drive_s wr_pin_next;
    pin_drive_s rd_pin_next;
    logic rd_active;
    logic wr_active;
    logic accept;
    logic is_ext;
    logic count_in_prev_reg;
    logic count_in_prev_next;
    logic count_fall_reg;
    logic count_fall_next;

    generate
        if (NUM_TIMERS < 2 || NUM_TIMERS > 3)
        begin : g_bad_timers
            $error("core_cycle_timing: NUM_TIMERS must be 2 or 3");
        end
        if (STRETCH_W < 1 || STRETCH_W > 4)
        begin : g_bad_stretch
            $error("core_cycle_timing: STRETCH_W must be 1 to 4");
        end
    endgenerate

    // Byte count zero is treated as a one byte opcode
    function automatic logic [2:0] cycles_for(input instr_s i);
        logic [2:0] n;
        case (i.kind)
            KIND_EXT_READ, KIND_EXT_WRITE: n = CYC_EXT_DATA;
            KIND_MOV_DIR_DIR: n = CYC_MOV_DIR_DIR;
            KIND_DATA_POINTER_INC: n = CYC_DATA_POINTER_INC;
            default: n = {1'b0, (i.bytes == 2'h0) ? 2'h1 : i.bytes} + CYC_EXEC_EXTRA;
        endcase
        return n;
    endfunction

    assign accept = instr_valid && instr_ready && (state_reg == ST_IDLE);
    assign is_ext = (instr.kind == KIND_EXT_READ) || (instr.kind == KIND_EXT_WRITE);

    always_comb
    begin
        state_next = state_reg;
        kind_next = kind_reg;
        cycles_left_next = cycles_left_reg;
        stretch_next = stretch_reg;
        stretch_cnt_next = stretch_cnt_reg;
        fetch_external_next = fetch_external;
        fetch_internal_next = fetch_internal;
        data_pointer_next = data_pointer;
        mc_end_next = 1'b0;
        done_next = 1'b0;
        case (state_reg)
            ST_STRAP:
            begin
                // First enabled clock after release catches the strap
                fetch_external_next = !program_source_select;
                fetch_internal_next = program_source_select;
                state_next = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (accept)
                begin
                    state_next = ST_EXEC;
                    kind_next = instr.kind;
                    cycles_left_next = cycles_for(instr);
                    stretch_next = is_ext ? mem_stretch : '0;
                    stretch_cnt_next = is_ext ? mem_stretch : '0;
                end
                else if (data_pointer_load)
                begin
                    data_pointer_next = data_pointer_value;
                end
            end
            ST_EXEC:
            begin
                if (stretch_cnt_reg != '0)
                begin
                    stretch_cnt_next = stretch_cnt_reg - STRETCH_W'(1);
                end
                else
                begin
                    // Without stretch every clock closes a machine cycle
                    mc_end_next = 1'b1;
                    stretch_cnt_next = stretch_reg;
                    if (cycles_left_reg == CYC_LAST)
                    begin
                        done_next = 1'b1;
                        state_next = ST_IDLE;
                        if (kind_reg == KIND_DATA_POINTER_INC)
                        begin
                            // Plain 16-bit wrap, no flag side effects
                            data_pointer_next = data_pointer + DATA_POINTER_STEP;
                        end
                    end
                    else
                    begin
                        cycles_left_next = cycles_left_reg - 3'h1;
                    end
                end
            end
            default:
            begin
                state_next = ST_STRAP;
            end
        endcase
        ready_next = (state_next == ST_IDLE);
        // Strobes only in the execution cycle of a real data access
        rd_active = (state_next == ST_EXEC) && (kind_next == KIND_EXT_READ)
            && (cycles_left_next == CYC_LAST);
        wr_active = (state_next == ST_EXEC) && (kind_next == KIND_EXT_WRITE)
            && (cycles_left_next == CYC_LAST);
        rd_pin_next = strobe_alt_en ? pin_drive_s'{out: !rd_active, oe: 1'b1} : PIN_RELEASED;
        wr_pin_next = strobe_alt_en ? pin_drive_s'{out: !wr_active, oe: 1'b1} : PIN_RELEASED;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_STRAP;
            kind_reg <= KIND_GENERAL;
            cycles_left_reg <= 3'h0;
            stretch_reg <= '0;
            stretch_cnt_reg <= '0;
            fetch_external <= 1'b0;
            fetch_internal <= 1'b0;
            instr_ready <= 1'b0;
            machine_cycle_end <= 1'b0;
            instr_done <= 1'b0;
            data_pointer <= DATA_POINTER_RESET;
            port_three_bit_six <= PIN_RELEASED;
            port_three_bit_seven <= PIN_RELEASED;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            cycles_left_reg <= cycles_left_next;
            stretch_reg <= stretch_next;
            stretch_cnt_reg <= stretch_cnt_next;
            fetch_external <= fetch_external_next;
            fetch_internal <= fetch_internal_next;
            instr_ready <= ready_next;
            machine_cycle_end <= mc_end_next;
            instr_done <= done_next;
            data_pointer <= data_pointer_next;
            port_three_bit_six <= wr_pin_next;
            port_three_bit_seven <= rd_pin_next;
        end
    end

    // Pin is synchronous to the clock, so a single stage edge detect suffices
    always_comb
    begin
        count_in_prev_next = port_three_bit_five;
        count_fall_next = count_in_prev_reg && !port_three_bit_five;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_in_prev_reg <= 1'b1;
            count_fall_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            count_in_prev_reg <= count_in_prev_next;
            count_fall_reg <= count_fall_next;
        end
    end

    genvar t;
    generate
        for (t = 0; t < NUM_TIMERS; t++)
        begin : g_timer
            timer_unit #(
                .WIDTH(16)
            ) u_timer (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .clk_en(clk_en),
                .run(timer_run[t]),
                .fast_sel(timer_fast_sel[t]),
                .count_mode(timer_count_mode[t]),
                .count_edge((t == 1) ? count_fall_reg : 1'b0),
                .value(timer_value[t])
            );
        end
    endgenerate

    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_accept(instr_kind_e k);
        clk_en && accept && instr.kind == k;
    endsequence

    property p_strap_low;
        (state_reg == ST_STRAP && clk_en && !program_source_select) |=>
            fetch_external && !fetch_internal;
    endproperty
    a_strap_low: assert property (p_strap_low)
        else $error("low strap did not select external fetch");

    property p_strap_high;
        (state_reg == ST_STRAP && clk_en && program_source_select) |=>
            fetch_internal && !fetch_external;
    endproperty
    a_strap_high: assert property (p_strap_high)
        else $error("high strap did not select internal fetch");

    property p_strap_held;
        (state_reg != ST_STRAP && $past(state_reg) != ST_STRAP) |->
            $stable(fetch_external) && $stable(fetch_internal);
    endproperty
    a_strap_held: assert property (p_strap_held)
        else $error("program source changed without reset");

    property p_one_byte;
        (s_accept(KIND_GENERAL) ##0 instr.bytes == 2'h1) ##1 clk_en [*2] |=>
            instr_done && instr_ready;
    endproperty
    a_one_byte: assert property (p_one_byte)
        else $error("one byte instruction not two clocks");

    property p_two_byte;
        (s_accept(KIND_GENERAL) ##0 instr.bytes == 2'h2) ##1 clk_en [*3] |->
            !instr_done ##1 instr_done;
    endproperty
    a_two_byte: assert property (p_two_byte)
        else $error("two byte instruction not three clocks");

    property p_ext_read;
        (s_accept(KIND_EXT_READ) ##0 mem_stretch == '0) ##1 clk_en [*2] |=> instr_done;
    endproperty
    a_ext_read: assert property (p_ext_read)
        else $error("external read not two clocks");

    property p_mov_dd;
        s_accept(KIND_MOV_DIR_DIR) ##1 clk_en [*3] |=> instr_done;
    endproperty
    a_mov_dd: assert property (p_mov_dd)
        else $error("direct move not three clocks");

    property p_data_pointer_inc;
        s_accept(KIND_DATA_POINTER_INC) ##1 clk_en |=>
            instr_done && data_pointer == $past(data_pointer, 2) + DATA_POINTER_STEP;
    endproperty
    a_data_pointer_inc: assert property (p_data_pointer_inc)
        else $error("pointer increment not single clock");

    property p_stretch_one;
        (s_accept(KIND_EXT_READ) ##0 mem_stretch == STRETCH_W'(1)) ##1 clk_en [*4] |=>
            instr_done;
    endproperty
    a_stretch_one: assert property (p_stretch_one)
        else $error("stretched read not four clocks");

    property p_rd_cause;
        (!port_three_bit_seven.out && port_three_bit_seven.oe) |->
            state_reg == ST_EXEC && kind_reg == KIND_EXT_READ;
    endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("read strobe without external read");

    property p_wr_pulse;
        ($fell(port_three_bit_six.out) && stretch_reg == '0 && clk_en) |=>
            port_three_bit_six.out && kind_reg == KIND_EXT_WRITE;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe not one machine cycle");

    property p_fast_timer;
        (clk_en && timer_run[NUM_TIMERS-1] && timer_fast_sel[NUM_TIMERS-1]
            && !timer_count_mode[NUM_TIMERS-1]) |=>
            timer_value[NUM_TIMERS-1] == $past(timer_value[NUM_TIMERS-1]) + 16'h0001;
    endproperty
    a_fast_timer: assert property (p_fast_timer)
        else $error("fast timer did not step each clock");

    property p_ext_count;
        (clk_en && timer_run[1] && timer_count_mode[1] && $fell(port_three_bit_five))
            ##1 (clk_en && timer_run[1] && timer_count_mode[1]) |=>
            timer_value[1] == $past(timer_value[1]) + 16'h0001;
    endproperty
    a_ext_count: assert property (p_ext_count)
        else $error("timer one missed external count");

endmodule

// File: src/timer_unit.sv
// One timer/counter with its own legacy or fast prescale selection.
// Assumes count_edge is a one-cycle pulse already formed by the caller.
`timescale 1ns/100ps
module timer_unit
    import core_timing_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic run,
    input wire logic fast_sel,
    input wire logic count_mode,
    input wire logic count_edge,
    output logic [WIDTH-1:0] value
);

    logic [3:0] prescale_reg;
    logic [3:0] prescale_next;
    logic [3:0] gap_reg;
    logic [3:0] gap_next;
    logic [WIDTH-1:0] value_next;
    logic tick;
    logic incr;

    generate
        if (WIDTH < 8 || WIDTH > 32)
        begin : g_bad_width
            $error("timer_unit: WIDTH must be 8 to 32");
        end
    endgenerate

    always_comb
    begin
        tick = fast_sel || (prescale_reg == PRESCALE_LAST);
        prescale_next = tick ? PRESCALE_RESET : prescale_reg + 4'h1;
        incr = run && (count_mode ? count_edge : tick);
        value_next = incr ? value + WIDTH'(1) : value;
        gap_next = (incr || fast_sel) ? 4'h0 : gap_reg + 4'h1;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prescale_reg <= PRESCALE_RESET;
            gap_reg <= 4'h0;
            value <= '0;
        end
        else if (clk_en)
        begin
            prescale_reg <= prescale_next;
            gap_reg <= gap_next;
            value <= value_next;
        end
    end

    // Gap counter is only watched here; it tracks clocks since the last step
    property p_legacy_spacing;
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && incr && !fast_sel && !count_mode && $past(!fast_sel)) |->
            (gap_reg == PRESCALE_LAST || gap_reg == 4'h0);
    endproperty
    a_legacy_spacing: assert property (p_legacy_spacing)
        else $error("timer slow step not twelve clocks apart");

endmodule
